/* File: psram_cfg_defs.svh */
// Constants for the pseudo-static memory configuration controller
`ifndef PSRAM_CFG_DEFS_SVH
`define PSRAM_CFG_DEFS_SVH

// ****************************************
// Clock and memory geometry
// ****************************************
`define CLK_NS         10
`define ADDR_W         21
`define DATA_W         16
`define TOP_ADDR       21'h01ffff

// ****************************************
// Configuration word layout
// ****************************************
`define CFG_DEFAULT    16'h0070
`define CFG_USED_MASK  16'h00f7
`define PAGE_BIT       7
`define BAND_HI        6
`define BAND_LO        5
`define SLEEP_SEL_BIT  4
`define PART_HI        2
`define PART_LO        0
`define PART_NONE      3'h4

// ****************************************
// Timing (figures as printed, counts derived)
// ****************************************
`define ACC_NS         70
`define ACC_CYC        ((`ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define ZZWE_NS        10
`define ZZWE_CYC       ((`ZZWE_NS + `CLK_NS - 1) / `CLK_NS)
`define ZZ_MIN_NS      10000
`define ZZ_MIN_CYC     (`ZZ_MIN_NS / `CLK_NS + 1)
`define INIT_US        150
`define INIT_CYC       ((`INIT_US * 1000) / `CLK_NS)

// ****************************************
// Controller register map
// ****************************************
`define REG_CFG        8'h00
`define REG_CMD        8'h04
`define REG_STATUS     8'h08
`define REG_READBACK   8'h0c
`define CMD_PIN_LOAD   0
`define CMD_SW_LOAD    1
`define CMD_SW_READ    2
`define CMD_SLEEP      3
`define CMD_WAKE       4
`define ST_BUSY        0
`define ST_ASLEEP      1
`define ST_INIT        2
`define ST_SW_LOADED   3
`define ST_REFUSED     4
`define ST_LOST        5
`define ST_NO_REFRESH  6
`define ST_PAR_ACTIVE  7
`define ST_DEEP_SEL    8

`endif

/* File: psram_cfg_pkg.sv */
// Types shared by the configuration controller and its access engine
package psram_cfg_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic [20:0] addr;
    logic [15:0] dq;
    logic        dq_oe_n;
  } mem_pins_t;

  typedef enum logic [1:0] {A_IDLE, A_ACTIVE, A_RECOVER} access_state_t;

  typedef enum logic [2:0] {
    C_IDLE, C_PIN_LOW, C_PIN_WRITE, C_PIN_RELEASE,
    C_SW_ACC, C_SLEEP_HOLD, C_ASLEEP, C_INIT_WAIT
  } ctrl_state_t;

endpackage

/* File: psram_access.sv */
// One asynchronous read or write cycle on the memory pins
`timescale 1ns/10ps
`include "psram_cfg_defs.svh"
module psram_access
  import psram_cfg_pkg::*;
(
  input  wire logic              mclk_in,
  input  wire logic              rst_in,
  input  wire logic              start_in,
  input  wire logic              write_in,
  input  wire logic [20:0]       addr_in,
  input  wire logic [15:0]       wdata_in,
  input  wire logic [15:0]       dq_in,
  output mem_pins_t              pins_out,
  output logic      [15:0]       rdata_out,
  output logic                   done_out
);

  localparam logic [3:0] ACC_LAST = 4'(`ACC_CYC - 1);

  access_state_t state_reg, state_next;
  logic [3:0]    cnt_reg, cnt_next;
  mem_pins_t     pins_reg, pins_next;
  logic [15:0]   rdata_reg, rdata_next;

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    pins_next  = pins_reg;
    rdata_next = rdata_reg;
    unique case (state_reg)
      A_IDLE:
        if (start_in)
        begin
          state_next        = A_ACTIVE;
          cnt_next          = ACC_LAST;
          pins_next.ce_n    = 1'b0;
          pins_next.we_n    = ~write_in;
          pins_next.oe_n    = write_in;
          pins_next.dq_oe_n = ~write_in;
          pins_next.addr    = addr_in;
          pins_next.dq      = wdata_in;
        end
      A_ACTIVE:
        if (cnt_reg == 4'h0)
        begin
          // Strobes rise together; data hold of zero is allowed
          state_next        = A_RECOVER;
          rdata_next        = dq_in;
          pins_next.ce_n    = 1'b1;
          pins_next.we_n    = 1'b1;
          pins_next.oe_n    = 1'b1;
          pins_next.dq_oe_n = 1'b1;
        end
        else
        begin
          cnt_next = cnt_reg - 4'h1;
        end
      A_RECOVER:
        state_next = A_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      state_reg <= A_IDLE;
      cnt_reg   <= 4'h0;
      pins_reg  <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 21'h000000, dq: 16'h0000, dq_oe_n: 1'b1};
      rdata_reg <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      pins_reg  <= pins_next;
      rdata_reg <= rdata_next;
    end
  end

  assign pins_out  = pins_reg;
  assign rdata_out = rdata_reg;
  assign done_out  = (state_reg == A_RECOVER);

endmodule // psram_access

/* File: psram_cfg_host.sv */
// Host controller that loads and reads the memory configuration word
`timescale 1ns/10ps
`include "psram_cfg_defs.svh"
module psram_cfg_host
  import psram_cfg_pkg::*;
#(
  parameter int INIT_CYC = `INIT_CYC
)
(
  input  wire logic         mclk_in,
  input  wire logic         rst_in,
  input  wb_req_t           wb_req_in,
  output logic [31:0]       wb_dat_out,
  output logic              wb_ack_out,
  input  wire logic [15:0]  dq_in,
  output mem_pins_t         mem_pins_out,
  output logic              sleep_request_n_out
);

  localparam logic [15:0] ZZ_LAST  = 16'(`ZZ_MIN_CYC - 1);
  localparam logic [15:0] ZZWE_CNT = 16'(`ZZWE_CYC);
  localparam logic [15:0] INIT_LAST = 16'(INIT_CYC - 1);

  generate
    if (INIT_CYC < 1 || INIT_CYC > 65535)
    begin : g_bad_init
      $error("INIT_CYC out of range for the 16-bit wait counter");
    end
  endgenerate

  // ****************************************
  // State
  // ****************************************
  ctrl_state_t state_reg, state_next;
  logic [15:0] cfg_reg, cfg_next;
  logic [15:0] dev_word_reg, dev_word_next;
  logic [15:0] readback_reg, readback_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [1:0]  step_reg, step_next;
  logic        read_seq_reg, read_seq_next;
  logic        sw_loaded_reg, sw_loaded_next;
  logic        refused_reg, refused_next;
  logic        lost_reg, lost_next;
  logic        sleep_n_reg, sleep_n_next;
  logic        acc_busy_reg, acc_busy_next;
  logic        ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;

  logic        acc_start;
  logic        acc_write;
  logic [20:0] acc_addr;
  logic [15:0] acc_wdata;
  logic [15:0] acc_rdata;
  logic        acc_done;
  logic        take;
  logic        cmd_wr;
  logic        deep_sel;
  logic [15:0] cfg_clean;
  logic [31:0] status;

  assign take      = wb_req_in.cyc & wb_req_in.stb & ~ack_reg;
  assign cmd_wr    = take & wb_req_in.we & wb_req_in.sel[0] & (wb_req_in.adr == `REG_CMD);
  assign cfg_clean = cfg_reg & `CFG_USED_MASK;
  assign deep_sel  = ~dev_word_reg[`SLEEP_SEL_BIT];

  always_comb
  begin
    status                = 32'h00000000;
    status[31:16]         = dev_word_reg;
    status[`ST_BUSY]      = (state_reg != C_IDLE);
    status[`ST_ASLEEP]    = (state_reg == C_ASLEEP);
    status[`ST_INIT]      = (state_reg == C_INIT_WAIT);
    status[`ST_SW_LOADED] = sw_loaded_reg;
    status[`ST_REFUSED]   = refused_reg;
    status[`ST_LOST]      = lost_reg;
    status[`ST_NO_REFRESH] = (dev_word_reg[`PART_HI:`PART_LO] == `PART_NONE);
    status[`ST_PAR_ACTIVE] = sw_loaded_reg & ~deep_sel;
    status[`ST_DEEP_SEL]  = deep_sel;
  end

  // ****************************************
  // Register bus
  // ****************************************
  always_comb
  begin
    ack_next = take;
    dat_next = dat_reg;
    cfg_next = cfg_reg;
    if (take & ~wb_req_in.we)
    begin
      unique case (wb_req_in.adr)
        `REG_CFG:      dat_next = {16'h0000, cfg_reg};
        `REG_STATUS:   dat_next = status;
        `REG_READBACK: dat_next = {16'h0000, readback_reg};
        default:       dat_next = 32'h00000000;
      endcase
    end
    // Band is passed on untouched; software owns the temperature choice
    if (take & wb_req_in.we & (wb_req_in.adr == `REG_CFG))
    begin
      if (wb_req_in.sel[0])
        cfg_next[7:0] = wb_req_in.dat[7:0];
      if (wb_req_in.sel[1])
        cfg_next[15:8] = wb_req_in.dat[15:8];
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    state_next     = state_reg;
    dev_word_next  = dev_word_reg;
    readback_next  = readback_reg;
    cnt_next       = cnt_reg;
    step_next      = step_reg;
    read_seq_next  = read_seq_reg;
    sw_loaded_next = sw_loaded_reg;
    refused_next   = refused_reg;
    lost_next      = lost_reg;
    sleep_n_next   = sleep_n_reg;
    acc_busy_next  = acc_busy_reg;
    acc_start      = 1'b0;
    acc_write      = 1'b0;
    acc_addr       = `TOP_ADDR;
    acc_wdata      = cfg_clean;
    // Write-one clears sticky flags; a same-cycle set below still wins
    if (take & wb_req_in.we & wb_req_in.sel[0] & (wb_req_in.adr == `REG_STATUS))
    begin
      if (wb_req_in.dat[`ST_REFUSED])
        refused_next = 1'b0;
      if (wb_req_in.dat[`ST_LOST])
        lost_next = 1'b0;
    end
    unique case (state_reg)
      C_IDLE:
        if (cmd_wr & wb_req_in.dat[`CMD_PIN_LOAD])
        begin
          state_next   = C_PIN_LOW;
          sleep_n_next = 1'b0;
          cnt_next     = ZZWE_CNT;
        end
        else if (cmd_wr & wb_req_in.dat[`CMD_SW_LOAD])
        begin
          if (~cfg_reg[`SLEEP_SEL_BIT] | deep_sel)
            refused_next = 1'b1;
          else
          begin
            state_next    = C_SW_ACC;
            step_next     = 2'h0;
            read_seq_next = 1'b0;
          end
        end
        else if (cmd_wr & wb_req_in.dat[`CMD_SW_READ])
        begin
          state_next    = C_SW_ACC;
          step_next     = 2'h0;
          read_seq_next = 1'b1;
        end
        else if (cmd_wr & wb_req_in.dat[`CMD_SLEEP])
        begin
          state_next   = C_SLEEP_HOLD;
          sleep_n_next = 1'b0;
          cnt_next     = ZZ_LAST;
        end
      C_PIN_LOW:
        if (cnt_reg == 16'h0000)
        begin
          acc_start  = 1'b1;
          acc_write  = 1'b1;
          acc_addr   = {5'h00, cfg_clean};
          state_next = C_PIN_WRITE;
        end
        else
          cnt_next = cnt_reg - 16'h0001;
      C_PIN_WRITE:
        if (acc_done)
        begin
          dev_word_next = cfg_clean;
          state_next    = C_PIN_RELEASE;
          sleep_n_next  = 1'b1;
        end
      C_PIN_RELEASE:
        state_next = C_IDLE;
      C_SW_ACC:
        if (~acc_busy_reg)
        begin
          acc_start     = 1'b1;
          acc_write     = step_reg[1] & ~(read_seq_reg & (step_reg == 2'h3));
          acc_busy_next = 1'b1;
        end
        else if (acc_done)
        begin
          acc_busy_next = 1'b0;
          step_next     = step_reg + 2'h1;
          if (step_reg == 2'h3)
          begin
            state_next = C_IDLE;
            if (read_seq_reg)
              readback_next = acc_rdata & `CFG_USED_MASK;
            else
            begin
              dev_word_next  = cfg_clean;
              sw_loaded_next = 1'b1;
            end
          end
        end
      C_SLEEP_HOLD:
        if (cnt_reg == 16'h0000)
        begin
          state_next = C_ASLEEP;
          if (deep_sel)
            lost_next = 1'b1;
        end
        else
          cnt_next = cnt_reg - 16'h0001;
      C_ASLEEP:
        if (cmd_wr & wb_req_in.dat[`CMD_WAKE])
        begin
          sleep_n_next = 1'b1;
          if (deep_sel)
          begin
            state_next = C_INIT_WAIT;
            cnt_next   = INIT_LAST;
          end
          else
            state_next = C_IDLE;
        end
      C_INIT_WAIT:
        if (cnt_reg == 16'h0000)
          state_next = C_IDLE;
        else
          cnt_next = cnt_reg - 16'h0001;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      state_reg     <= C_IDLE;
      cfg_reg       <= `CFG_DEFAULT;
      dev_word_reg  <= `CFG_DEFAULT;
      readback_reg  <= 16'h0000;
      cnt_reg       <= 16'h0000;
      step_reg      <= 2'h0;
      read_seq_reg  <= 1'b0;
      sw_loaded_reg <= 1'b0;
      refused_reg   <= 1'b0;
      lost_reg      <= 1'b0;
      sleep_n_reg   <= 1'b1;
      acc_busy_reg  <= 1'b0;
      ack_reg       <= 1'b0;
      dat_reg       <= 32'h00000000;
    end
    else
    begin
      state_reg     <= state_next;
      cfg_reg       <= cfg_next;
      dev_word_reg  <= dev_word_next;
      readback_reg  <= readback_next;
      cnt_reg       <= cnt_next;
      step_reg      <= step_next;
      read_seq_reg  <= read_seq_next;
      sw_loaded_reg <= sw_loaded_next;
      refused_reg   <= refused_next;
      lost_reg      <= lost_next;
      sleep_n_reg   <= sleep_n_next;
      acc_busy_reg  <= acc_busy_next;
      ack_reg       <= ack_next;
      dat_reg       <= dat_next;
    end
  end

  psram_access u_access (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .start_in  (acc_start),
    .write_in  (acc_write),
    .addr_in   (acc_addr),
    .wdata_in  (acc_wdata),
    .dq_in     (dq_in),
    .pins_out  (mem_pins_out),
    .rdata_out (acc_rdata),
    .done_out  (acc_done)
  );

  assign wb_ack_out          = ack_reg;
  assign wb_dat_out          = dat_reg;
  assign sleep_request_n_out = sleep_n_reg;

  // ****************************************
  // Checks
  // ****************************************
  // Judged on the pins themselves, so a slip in the access engine is caught too
  a_reserved_zero: assert property (@(posedge mclk_in) disable iff (rst_in)
    !mem_pins_out.we_n |-> (mem_pins_out.dq[15:8] == 8'h00 && mem_pins_out.dq[3] == 1'b0
                            && (mem_pins_out.addr == `TOP_ADDR
                                || (mem_pins_out.addr[20:8] == 13'h0000 && mem_pins_out.addr[3] == 1'b0))))
    else $error("reserved bits driven nonzero");
  a_sw_no_deep: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_reg == C_IDLE && state_next == C_SW_ACC && !read_seq_next) |-> (cfg_reg[4] && dev_word_reg[4]))
    else $error("software sequence would change deep sleep");
  a_init_quiet: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_reg == C_INIT_WAIT && cnt_reg != 16'h0000) |=> (state_reg == C_INIT_WAIT && mem_pins_out.ce_n))
    else $error("access during initialization wait");
  a_init_length: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_reg == C_ASLEEP && state_next == C_INIT_WAIT) |=> cnt_reg == INIT_LAST)
    else $error("initialization wait wrong length");
  a_band_passed: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_reg == C_PIN_WRITE && acc_done) |=> dev_word_reg[6:5] == $past(cfg_reg[6:5]))
    else $error("temperature band altered");
  a_pin_write: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_reg == C_IDLE && state_next == C_PIN_LOW) |=> !sleep_request_n_out ##[1:50] !mem_pins_out.we_n)
    else $error("pin load write not within window");
  a_top_addr: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_reg == C_SW_ACC && !mem_pins_out.ce_n) |-> mem_pins_out.addr == `TOP_ADDR)
    else $error("software access off top address");
  a_hold_low: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_reg == C_SLEEP_HOLD && cnt_reg != 16'h0000) |=> (!sleep_request_n_out && state_reg == C_SLEEP_HOLD))
    else $error("sleep pin released early");

  c_pin_load: cover property (@(posedge mclk_in) disable iff (rst_in) state_reg == C_PIN_RELEASE);
  c_sw_load: cover property (@(posedge mclk_in) disable iff (rst_in) $rose(sw_loaded_reg));
  c_deep_wake: cover property (@(posedge mclk_in) disable iff (rst_in) state_reg == C_INIT_WAIT);

endmodule // psram_cfg_host

/* File: psram_dev_model.sv */
// Behavioural model of the memory device and its configuration word
`timescale 1ns/10ps
module psram_dev_model
  import psram_cfg_pkg::*;
#(
  parameter int INIT_NS = 200
)
(
  input  mem_pins_t        pins_in,
  input  wire logic        sleep_request_n_in,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out,
  output logic      [15:0] word_out,
  output logic             deep_out,
  output logic             par_out,
  output int               n_err_out
);
  // ****************************************
  // Configuration word and low-power modes
  // ****************************************
  logic [15:0] word_reg    = 16'h0070;
  logic [15:0] top_reg     = 16'h5a5a;
  logic [15:0] wdat_reg    = 16'h0000;
  logic [15:0] last_reg    = 16'h0000;
  logic        armed_reg   = 1'b0;
  logic        wr_reg      = 1'b0;
  logic        sw_reg      = 1'b0;
  logic        pin_par_reg = 1'b0;
  int          seq_reg     = 0;
  realtime     t_fall      = 0.0;
  realtime     t_wake      = -1.0e9;

  initial
  begin
    deep_out = 1'b0;
    n_err_out = 0;
  end

  assign word_out = word_reg;
  assign par_out = sw_reg ? word_reg[4] : pin_par_reg;
  // Released bus shows the inverse, so a stale sample cannot pass
  assign dq_out = (!pins_in.ce_n && !pins_in.oe_n) ? last_reg : ~last_reg;

  always @*
    if (!pins_in.ce_n && !pins_in.oe_n) last_reg = (seq_reg == 3) ? word_reg : top_reg;

  always @(negedge sleep_request_n_in)
  begin
    armed_reg = 1'b1;
    t_fall = $realtime;
  end

  // Polled so that a short pin-load pulse never hides a later fall
  always #50
  begin
    if (sleep_request_n_in === 1'b0 && $realtime - t_fall > 10000.0)
    begin
      if (!word_reg[4]) deep_out = 1'b1;
      else if (!sw_reg) pin_par_reg = 1'b1;
    end
  end

  always @(posedge sleep_request_n_in)
  begin
    if (deep_out) t_wake = $realtime;
    deep_out = 1'b0;
    pin_par_reg = 1'b0;
  end

  always @(negedge pins_in.we_n)
  begin
    wr_reg = 1'b1;
    #1 wdat_reg = dq_in;
  end

  // Judged at the start of an access, so one that merely ends late still counts
  always @(negedge pins_in.ce_n)
    if ($realtime - t_wake < INIT_NS) n_err_out++;

  always @(posedge pins_in.ce_n)
  begin
    if (wr_reg && armed_reg)
    begin
      if (pins_in.addr[20:8] != 13'h0 || pins_in.addr[3]) n_err_out++;
      word_reg = pins_in.addr[15:0];
      seq_reg = 0;
    end
    else if (pins_in.addr !== 21'h01ffff) seq_reg = 0;
    else if (seq_reg < 2) seq_reg = wr_reg ? 0 : seq_reg + 1;
    else if (seq_reg == 2) seq_reg = wr_reg ? 3 : 0;
    else
    begin
      if (wr_reg)
      begin
        if (wdat_reg[15:8] != 8'h0 || wdat_reg[3] || !wdat_reg[4] || !word_reg[4]) n_err_out++;
        word_reg = wdat_reg;
        sw_reg = 1'b1;
      end
      seq_reg = 0;
    end
    armed_reg = 1'b0;
    wr_reg = 1'b0;
  end
endmodule // psram_dev_model

/* File: tb_psram_cfg_host.sv */
// Self-checking bench for the configuration controller
`timescale 1ns/10ps
`include "psram_cfg_defs.svh"
module tb_psram_cfg_host;
  import psram_cfg_pkg::*;
  logic        mclk_in    = 1'b0;
  logic        rst_in     = 1'b1;
  wb_req_t     req        = '0;
  logic [31:0] wb_dat;
  logic        wb_ack;
  mem_pins_t   pins;
  logic        sleep_n;
  logic [15:0] dev_dq;
  logic [15:0] dq_wire;
  logic [15:0] dev_word;
  logic        dev_deep;
  logic        dev_par;
  int          dev_err;
  logic [31:0] d;
  int          fails      = 0;
  int          n_compared = 0;

  always #5 mclk_in = ~mclk_in;
  assign dq_wire = (pins.dq_oe_n === 1'b0) ? pins.dq : dev_dq;

  psram_cfg_host #(.INIT_CYC(20)) i_psram_cfg_host (.mclk_in(mclk_in), .rst_in(rst_in), .wb_req_in(req),
    .wb_dat_out(wb_dat), .wb_ack_out(wb_ack), .dq_in(dq_wire), .mem_pins_out(pins), .sleep_request_n_out(sleep_n));
  psram_dev_model #(.INIT_NS(200)) i_psram_dev_model (.pins_in(pins), .sleep_request_n_in(sleep_n),
    .dq_in(dq_wire), .dq_out(dev_dq), .word_out(dev_word), .deep_out(dev_deep), .par_out(dev_par),
    .n_err_out(dev_err));

  // ****************************************
  // Bus and checking helpers
  // ****************************************
  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Classic single cycle; ack judged at rising edges, only the watchdog ends a hang
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge mclk_in);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    do
    begin
      @(posedge mclk_in);
      n++;
    end
    while (wb_ack !== 1'b1);
    check(n, 32'h2, "ack latency");
    d = wb_dat;
    req <= '0;
  endtask

  task automatic run(input int cmd, input int st, input logic val);
    int n;
    if (cmd >= 0) wb(1'b1, `REG_CMD, 32'h1 << cmd);
    for (n = 0; n < 2000; n++)
    begin
      wb(1'b0, `REG_STATUS, 32'h0);
      if (d[st] === val) break;
    end
    check({31'h0, d[st]}, {31'h0, val}, "status wait");
  endtask

  task automatic pin_load(input logic [15:0] w);
    wb(1'b1, `REG_CFG, {16'h0, w});
    run(`CMD_PIN_LOAD, `ST_BUSY, 1'b0);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    wb(1'b0, `REG_CFG, 32'h0);
    check(d, 32'h0000_0070, "cfg reset");
    wb(1'b0, `REG_STATUS, 32'h0);
    check(d, 32'h0070_0000, "status reset");
    check({16'h0, dev_word}, 32'h0070, "device default");
    wb(1'b1, 8'h10, 32'hffff_ffff);
    wb(1'b0, 8'h10, 32'h0);
    check(d, 32'h0, "unmapped read");
  endtask

  // Every band, page setting and partial code, reserved bits forced high
  task automatic t_codes;
    logic [15:0] w;
    logic [15:0] e;
    for (int i = 0; i < 8; i++)
    begin
      w = 16'hff18 | 16'(i) | (16'(i & 3) << 5) | (16'(i & 1) << 7);
      e = w & `CFG_USED_MASK;
      pin_load(w);
      check({16'h0, dev_word}, {16'h0, e}, "pin word");
      wb(1'b0, `REG_STATUS, 32'h0);
      check({16'h0, d[31:16]}, {16'h0, e}, "shadow");
      check({31'h0, d[`ST_NO_REFRESH]}, {31'h0, i == 4}, "code");
    end
  endtask

  task automatic t_swread;
    run(`CMD_SW_READ, `ST_BUSY, 1'b0);
    wb(1'b0, `REG_READBACK, 32'h0);
    check(d, 32'h0000_00f7, "readback");
    check({16'h0, dev_word}, 32'h00f7, "word kept");
  endtask

  task automatic t_deep;
    pin_load(16'h0060);
    wb(1'b0, `REG_STATUS, 32'h0);
    check({31'h0, d[`ST_DEEP_SEL]}, 32'h1, "deep selected");
    run(`CMD_SLEEP, `ST_ASLEEP, 1'b1);
    repeat (10) @(posedge mclk_in);
    check({31'h0, dev_deep}, 32'h1, "deep entered");
    wb(1'b0, `REG_STATUS, 32'h0);
    check({31'h0, d[`ST_LOST]}, 32'h1, "lost");
    wb(1'b1, `REG_CMD, 32'h1 << `CMD_WAKE);
    wb(1'b0, `REG_STATUS, 32'h0);
    check({31'h0, d[`ST_INIT]}, 32'h1, "init wait");
    run(-1, `ST_INIT, 1'b0);
    check({31'h0, dev_deep}, 32'h0, "deep left");
    wb(1'b1, `REG_STATUS, 32'h1 << `ST_LOST);
    wb(1'b0, `REG_STATUS, 32'h0);
    check({31'h0, d[`ST_LOST]}, 32'h0, "lost clear");
  endtask

  // Device still in deep-sleep selection: software path must refuse
  task automatic t_refuse;
    wb(1'b1, `REG_CFG, 32'h0070);
    run(`CMD_SW_LOAD, `ST_BUSY, 1'b0);
    check({31'h0, d[`ST_REFUSED]}, 32'h1, "refused");
    check({16'h0, dev_word}, 32'h0060, "word unchanged");
  endtask

  task automatic t_swload;
    pin_load(16'h0070);
    wb(1'b1, `REG_STATUS, 32'h1 << `ST_REFUSED);
    wb(1'b1, `REG_CFG, 32'h0000_ff7c);
    run(`CMD_SW_LOAD, `ST_BUSY, 1'b0);
    check({16'h0, dev_word}, 32'h0074, "sw word");
    check({31'h0, dev_par}, 32'h1, "partial at once");
    check(d & 32'hffff_01ff, 32'h0074_00c8, "sw status");
    run(`CMD_SLEEP, `ST_ASLEEP, 1'b1);
    run(`CMD_WAKE, `ST_ASLEEP, 1'b0);
    check({31'h0, dev_deep}, 32'h0, "no deep");
  endtask

  // Band stays at its highest setting outside the sweep
  initial
  begin
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_reset;
    t_codes;
    t_swread;
    t_deep;
    t_refuse;
    t_swload;
    check(dev_err, 32'h0, "device protocol");
    stop_test;
  end

  initial
  begin
    #600000;
    fails++;
    stop_test;
  end
endmodule // tb_psram_cfg_host
